// ---- tpc_regs.svh ----
// Constants for the phase counting and buffered timer block.
// Included by the general register and top-level design files of the block; definitions only.
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// Counter limits and reset values
`define TPC_CNT_ZERO    16'h0000
`define TPC_CNT_TOP     16'hffff
`define TPC_FLAG_RST    8'h00

// Channel 3/4 operating modes
`define TPC_MODE_NORMAL 2'h0
`define TPC_MODE_RSYNC  2'h1
`define TPC_MODE_COMPL  2'h2

// Per-register capture/compare select
`define TPC_IO_COMPARE  2'h0
`define TPC_IO_CAP_RISE 2'h1
`define TPC_IO_CAP_FALL 2'h2
`define TPC_IO_CAP_BOTH 2'h3

// Channel 2 counter clear source
`define TPC_CLR_NONE    2'h0
`define TPC_CLR_A       2'h1
`define TPC_CLR_B       2'h2

// General register slots
`define TPC_GR_A2       0
`define TPC_GR_B2       1
`define TPC_GR_A3       2
`define TPC_GR_B3       3
`define TPC_GR_B4       4
`define TPC_GR_NUM      5

// Status flag positions
`define TPC_F_A2        0
`define TPC_F_B2        1
`define TPC_F_W2        2
`define TPC_F_A3        3
`define TPC_F_B3        4
`define TPC_F_W3        5
`define TPC_F_B4        6
`define TPC_F_W4        7

`endif

// ---- tpc_pkg.sv ----
// Types shared by the phase counting and buffered timer block.
// Needs nothing but the tool's SystemVerilog support.
package tpc_pkg;
	typedef logic [15:0] tpc_word_t;
	typedef logic [1:0]  tpc_sel_t;
	typedef logic [7:0]  tpc_flags_t;
	// Count direction of channels 3/4 in complementary mode
	typedef enum logic {
		TPC_UP,
		TPC_DOWN
	} tpc_dir_t;
endpackage

// ---- tpc_pin_sync.sv ----
// Two-stage synchroniser with edge detection for timer pins.
// Assumes pins are asynchronous to sys_clk.
`timescale 1ns/10ps
module tpc_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] prev_ff;

	// Two flops, then a history flop for edges
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// Levels and one-cycle edge pulses
	assign level = sync_ff;
	assign rise  = sync_ff & ~prev_ff;
	assign fall  = ~sync_ff & prev_ff;
endmodule

// ---- tpc_gen_reg.sv ----
// One general register with its optional buffer register.
// Events arrive as one-cycle pulses on sys_clk.
`timescale 1ns/10ps
`include "tpc_regs.svh"
module tpc_gen_reg
	import tpc_pkg::*;
(
	input  wire logic      sys_clk,
	input  wire logic      rst_n,
	input  wire tpc_word_t cnt,
	input  wire logic      is_compare,
	input  wire logic      buf_en,
	input  wire logic      xfer,
	input  wire logic      cap,
	input  wire logic      gr_wr,
	input  wire logic      br_wr,
	input  wire tpc_word_t wdata,
	output tpc_word_t      gr_ff,
	output tpc_word_t      br_ff
);
	tpc_word_t nxt_gr;
	tpc_word_t nxt_br;
	logic      cap_hit;
	logic      buf_hit;

	assign cap_hit = cap & ~is_compare;
	assign buf_hit = xfer & buf_en & is_compare;

	// Capture beats a write; a write beats a buffer transfer
	assign nxt_gr = cap_hit ? cnt :
		gr_wr ? wdata :
		buf_hit ? br_ff : gr_ff;

	// Capture pushes the old value down ahead of a write
	assign nxt_br = (cap_hit & buf_en) ? gr_ff :
		br_wr ? wdata : br_ff;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gr_ff <= `TPC_CNT_TOP;
			br_ff <= `TPC_CNT_TOP;
		end else begin
			gr_ff <= nxt_gr;
			br_ff <= nxt_br;
		end
	end
endmodule

// ---- tpc_top.sv ----
// Timer channels 2-4: phase counting, buffered registers, flags.
// Count ticks come from a prescaler on sys_clk; pins are async.
`timescale 1ns/10ps
`include "tpc_regs.svh"
module tpc_top
	import tpc_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       phase_input_a,
	input  wire logic       phase_input_b,
	input  wire logic       timer_pin_a_two_in,
	input  wire logic       timer_pin_b_two_in,
	input  wire logic       timer_pin_a_three_in,
	input  wire logic       timer_pin_b_three_in,
	input  wire logic       timer_pin_b_four_in,
	input  wire logic       phase_mode_bit,
	input  wire logic       start_ch_two,
	input  wire logic       start_ch_three,
	input  wire logic       start_ch_four,
	input  wire logic       tick_two,
	input  wire logic       tick_three,
	input  wire logic       tick_four,
	input  wire tpc_sel_t   clear_source_select,
	input  wire tpc_sel_t   pwm_mode,
	input  wire tpc_sel_t   io_sel_a_two,
	input  wire tpc_sel_t   io_sel_b_two,
	input  wire tpc_sel_t   io_sel_a_three,
	input  wire tpc_sel_t   io_sel_b_three,
	input  wire tpc_sel_t   io_sel_b_four,
	input  wire logic       buffer_enable_a_three,
	input  wire logic       buffer_enable_b_three,
	input  wire logic       buffer_enable_b_four,
	input  wire logic       level_select_three,
	input  wire logic       level_select_four,
	input  wire tpc_flags_t irq_enable,
	input  wire logic [4:0] gr_wr,
	input  wire logic [4:0] br_wr,
	input  wire logic [2:0] cnt_wr,
	input  wire tpc_word_t  wdata,
	input  wire logic       status_rd,
	input  wire logic       status_wr,
	input  wire tpc_flags_t status_wdata,
	output tpc_word_t       counter_ch_two,
	output tpc_word_t       counter_ch_three,
	output tpc_word_t       counter_ch_four,
	output tpc_flags_t      status_flags,
	output tpc_flags_t      irq_req,
	output logic            timer_pin_a_three_out,
	output logic            timer_pin_b_three_out,
	output logic            timer_pin_b_four_out,
	output logic            pwm_drive
);
	// Capture edge decode, shared by all five registers
	function automatic logic cap_hit(tpc_sel_t sel, logic r, logic f);
		return ((sel == `TPC_IO_CAP_RISE) & r) |
			((sel == `TPC_IO_CAP_FALL) & f) |
			((sel == `TPC_IO_CAP_BOTH) & (r | f));
	endfunction

	logic [6:0]         pin_lvl;
	logic [6:0]         pin_rise;
	logic [6:0]         pin_fall;
	tpc_word_t          cnt2_ff;
	tpc_word_t          cnt3_ff;
	tpc_word_t          cnt4_ff;
	tpc_word_t          nxt_cnt2;
	tpc_word_t          nxt_cnt3;
	tpc_word_t          nxt_cnt4;
	tpc_dir_t           dir_ff;
	tpc_dir_t           nxt_dir;
	tpc_flags_t         flag_ff;
	tpc_flags_t         nxt_flag;
	tpc_flags_t         armed_ff;
	tpc_flags_t         nxt_armed;
	tpc_flags_t         flag_set;
	tpc_flags_t         flag_clr;
	tpc_flags_t         irq_ff;
	logic               pa3_ff;
	logic               pb3_ff;
	logic               pb4_ff;
	logic               drive_ff;
	tpc_word_t          gr      [`TPC_GR_NUM];
	tpc_word_t          br      [`TPC_GR_NUM];
	tpc_word_t          reg_cnt [`TPC_GR_NUM];
	tpc_sel_t           io_sel  [`TPC_GR_NUM];
	logic [`TPC_GR_NUM-1:0] reg_adv;
	logic [`TPC_GR_NUM-1:0] is_cmp;
	logic [`TPC_GR_NUM-1:0] mt;
	logic [`TPC_GR_NUM-1:0] cap;
	logic [`TPC_GR_NUM-1:0] xfer;
	logic [`TPC_GR_NUM-1:0] buf_en;
	logic               q_up;
	logic               q_dn;
	logic               up2;
	logic               dn2;
	logic               adv2;
	logic               clear2;
	logic               wrap2;
	logic               compl;
	logic               rsync;
	logic               adv3;
	logic               adv4;
	logic               down34;
	logic               a3_hit;
	logic               a3_up_hit;
	logic               uf4;
	logic               wrap3;
	logic               wrap4;
	logic               clear3;
	logic               pwm3;
	logic               pwm4;

	// Quadrature and capture pins through two flops first
	tpc_pin_sync #(
		.W(7)
	) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pin_in  ({timer_pin_b_four_in, timer_pin_b_three_in, timer_pin_a_three_in,
			timer_pin_b_two_in, timer_pin_a_two_in, phase_input_b, phase_input_a}),
		.level   (pin_lvl),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	// Quadrature step decode, bit 0 is A and bit 1 is B
	assign q_up = (pin_rise[1] & ~pin_lvl[0]) | (pin_rise[0] & pin_lvl[1]) |
		(pin_fall[1] & pin_lvl[0]) | (pin_fall[0] & ~pin_lvl[1]);
	assign q_dn = (pin_rise[1] & pin_lvl[0]) | (pin_fall[0] & pin_lvl[1]) |
		(pin_fall[1] & ~pin_lvl[0]) | (pin_rise[0] & ~pin_lvl[1]);

	// Channel 2 count source: pins in phase mode, else prescaler
	assign up2  = phase_mode_bit ? q_up : tick_two;
	assign dn2  = phase_mode_bit & q_dn;
	assign adv2 = start_ch_two & (up2 | dn2);

	// Channels 3/4 mode decode
	assign compl  = (pwm_mode == `TPC_MODE_COMPL);
	assign rsync  = (pwm_mode == `TPC_MODE_RSYNC);
	assign down34 = compl & (dir_ff == TPC_DOWN);
	assign adv3   = start_ch_three & tick_three;
	assign adv4   = compl ? (adv3 & start_ch_four) : (start_ch_four & tick_four);

	// Per-register counter, advance and function select
	assign reg_cnt[`TPC_GR_A2] = cnt2_ff;
	assign reg_cnt[`TPC_GR_B2] = cnt2_ff;
	assign reg_cnt[`TPC_GR_A3] = cnt3_ff;
	assign reg_cnt[`TPC_GR_B3] = cnt3_ff;
	assign reg_cnt[`TPC_GR_B4] = rsync ? cnt3_ff : cnt4_ff;
	assign reg_adv = {rsync ? adv3 : adv4, adv3, adv3, adv2, adv2};
	assign io_sel[`TPC_GR_A2] = io_sel_a_two;
	assign io_sel[`TPC_GR_B2] = io_sel_b_two;
	assign io_sel[`TPC_GR_A3] = io_sel_a_three;
	assign io_sel[`TPC_GR_B3] = io_sel_b_three;
	assign io_sel[`TPC_GR_B4] = io_sel_b_four;
	assign buf_en = {buffer_enable_b_four, buffer_enable_b_three,
		buffer_enable_a_three, 2'b00};

	// Channel 3/4 reversal and transfer points
	assign a3_hit    = mt[`TPC_GR_A3];
	assign a3_up_hit = a3_hit & ~down34;
	assign uf4       = compl & down34 & adv4 & (cnt4_ff == `TPC_CNT_ZERO);

	// Match on leaving the matching count, capture on pin edge
	genvar gi;
	generate
		for (gi = 0; gi < `TPC_GR_NUM; gi++) begin : g_reg
			assign is_cmp[gi] = (io_sel[gi] == `TPC_IO_COMPARE);
			assign mt[gi] = is_cmp[gi] & reg_adv[gi] &
				(reg_cnt[gi] == gr[gi]);
			assign cap[gi] = cap_hit(io_sel[gi], pin_rise[gi + 2],
				pin_fall[gi + 2]);
			if (gi < `TPC_GR_A3) begin : g_nobuf
				assign xfer[gi] = 1'b0;
			end else begin : g_buf
				assign xfer[gi] = compl ? (a3_up_hit | uf4) :
					rsync ? a3_hit :
					mt[gi];
			end
			tpc_gen_reg u_gr (
				.sys_clk    (sys_clk),
				.rst_n      (rst_n),
				.cnt        (reg_cnt[gi]),
				.is_compare (is_cmp[gi]),
				.buf_en     (buf_en[gi]),
				.xfer       (xfer[gi]),
				.cap        (cap[gi]),
				.gr_wr      (gr_wr[gi]),
				.br_wr      (br_wr[gi]),
				.wdata      (wdata),
				.gr_ff      (gr[gi]),
				.br_ff      ()
			);
		end
	endgenerate

	// Channel 2 clear on selected match or capture
	assign clear2 = ((clear_source_select == `TPC_CLR_A) &
		(mt[`TPC_GR_A2] | cap[`TPC_GR_A2])) |
		((clear_source_select == `TPC_CLR_B) &
		(mt[`TPC_GR_B2] | cap[`TPC_GR_B2]));

	// Channel 2 wrap in either direction
	assign wrap2 = adv2 & ~clear2 & ((up2 & (cnt2_ff == `TPC_CNT_TOP)) |
		(dn2 & (cnt2_ff == `TPC_CNT_ZERO)));

	// Channel 2 next count: clear beats write beats step
	assign nxt_cnt2 = clear2 ? `TPC_CNT_ZERO :
		cnt_wr[0] ? wdata :
		~adv2 ? cnt2_ff :
		up2 ? cnt2_ff + 16'h0001 : cnt2_ff - 16'h0001;

	// Channel 3 clears on period match in reset-synchronized mode
	assign clear3 = rsync & a3_hit;
	assign nxt_cnt3 = clear3 ? `TPC_CNT_ZERO :
		cnt_wr[1] ? wdata :
		~adv3 ? cnt3_ff :
		down34 ? cnt3_ff - 16'h0001 : cnt3_ff + 16'h0001;
	assign nxt_cnt4 = cnt_wr[2] ? wdata :
		~adv4 ? cnt4_ff :
		down34 ? cnt4_ff - 16'h0001 : cnt4_ff + 16'h0001;

	// Channel 3/4 wraps; channel 4 counts underflow only when complementary
	assign wrap3 = adv3 & ~clear3 & (down34 ? (cnt3_ff == `TPC_CNT_ZERO) :
		(cnt3_ff == `TPC_CNT_TOP));
	assign wrap4 = compl ? uf4 :
		(adv4 & (cnt4_ff == `TPC_CNT_TOP));

	// Direction turns at the overshoot and undershoot points
	always_comb begin
		nxt_dir = dir_ff;
		unique case (dir_ff)
			TPC_UP: begin
				if (compl & a3_hit) begin
					nxt_dir = TPC_DOWN;
				end
			end
			TPC_DOWN: begin
				if (~compl | uf4) begin
					nxt_dir = TPC_UP;
				end
			end
		endcase
	end

	// Flag sources: match or capture, plus wrap, per channel
	assign flag_set[`TPC_F_A2] = mt[`TPC_GR_A2] | cap[`TPC_GR_A2];
	assign flag_set[`TPC_F_B2] = mt[`TPC_GR_B2] | cap[`TPC_GR_B2];
	assign flag_set[`TPC_F_W2] = wrap2;
	assign flag_set[`TPC_F_A3] = a3_up_hit | cap[`TPC_GR_A3];
	assign flag_set[`TPC_F_B3] = mt[`TPC_GR_B3] | cap[`TPC_GR_B3];
	assign flag_set[`TPC_F_W3] = wrap3;
	assign flag_set[`TPC_F_B4] = mt[`TPC_GR_B4] | cap[`TPC_GR_B4];
	assign flag_set[`TPC_F_W4] = wrap4;

	// Clear only bits read as one and then written zero; set wins
	assign flag_clr  = status_wr ? (armed_ff & ~status_wdata) : '0;
	assign nxt_flag  = flag_set | (flag_ff & ~flag_clr);
	assign nxt_armed = status_rd ? flag_ff :
		(armed_ff & ~flag_clr);

	// PWM levels: compare beyond period never crossed, 0% duty
	assign pwm3 = (compl | rsync) & (cnt3_ff > gr[`TPC_GR_B3]);
	assign pwm4 = (compl | rsync) &
		(reg_cnt[`TPC_GR_B4] > gr[`TPC_GR_B4]);

	// Counters and direction
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt2_ff <= `TPC_CNT_ZERO;
			cnt3_ff <= `TPC_CNT_ZERO;
			cnt4_ff <= `TPC_CNT_ZERO;
			dir_ff  <= TPC_UP;
		end else begin
			cnt2_ff <= nxt_cnt2;
			cnt3_ff <= nxt_cnt3;
			cnt4_ff <= nxt_cnt4;
			dir_ff  <= nxt_dir;
		end
	end

	// Status flags, read snapshot and interrupt requests
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_ff  <= `TPC_FLAG_RST;
			armed_ff <= `TPC_FLAG_RST;
			irq_ff   <= `TPC_FLAG_RST;
		end else begin
			flag_ff  <= nxt_flag;
			armed_ff <= nxt_armed;
			irq_ff   <= nxt_flag & irq_enable;
		end
	end

	// Output pins with level select; low select inverts
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pa3_ff   <= 1'b0;
			pb3_ff   <= 1'b0;
			pb4_ff   <= 1'b0;
			drive_ff <= 1'b0;
		end else begin
			pa3_ff   <= level_select_three ? pwm3 : ~pwm3;
			pb3_ff   <= level_select_three ? ~pwm3 : pwm3;
			pb4_ff   <= level_select_four ? pwm4 : ~pwm4;
			drive_ff <= compl | rsync;
		end
	end

	assign counter_ch_two        = cnt2_ff;
	assign counter_ch_three      = cnt3_ff;
	assign counter_ch_four       = cnt4_ff;
	assign status_flags          = flag_ff;
	assign irq_req               = irq_ff;
	assign timer_pin_a_three_out = pa3_ff;
	assign timer_pin_b_three_out = pb3_ff;
	assign timer_pin_b_four_out  = pb4_ff;
	assign pwm_drive             = drive_ff;
endmodule

// ---- tpc_top_asserts.sv ----
// Port-level properties of the phase counting and buffered timer.
// Bound to tpc_top; one clock domain, async active-low reset.
`timescale 1ns/10ps
module tpc_chk
	import tpc_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       phase_input_a,
	input wire logic       phase_input_b,
	input wire logic       timer_pin_a_two_in,
	input wire logic       phase_mode_bit,
	input wire logic       start_ch_two,
	input wire logic       start_ch_three,
	input wire tpc_sel_t   clear_source_select,
	input wire tpc_sel_t   pwm_mode,
	input wire tpc_sel_t   io_sel_a_two,
	input wire logic       level_select_three,
	input wire tpc_flags_t irq_enable,
	input wire logic [4:0] gr_wr,
	input wire logic [2:0] cnt_wr,
	input wire logic       status_wr,
	input wire tpc_word_t  counter_ch_two,
	input wire tpc_flags_t status_flags,
	input wire tpc_flags_t irq_req,
	input wire logic       timer_pin_a_three_out
);
	// Single domain
	default clocking dck @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// Request follows flag and enable
	a_irq_mask_flag:
		assert property (irq_req == (status_flags & $past(irq_enable)))
		else $error("irq_req differs from enabled flags");
	a_flag_hold:
		assert property (!$past(status_wr) |->
			(status_flags & $past(status_flags)) == $past(status_flags))
		else $error("flag fell without a status write");
	// Wrap flags in both directions
	a_wrap_up:
		assert property ($past(counter_ch_two) == 16'hffff && counter_ch_two == 16'h0000 &&
			$past(cnt_wr) == 3'h0 && $past(clear_source_select) == 2'h0 |-> status_flags[2])
		else $error("no wrap flag on overflow");
	a_wrap_down:
		assert property ($past(counter_ch_two) == 16'h0000 && counter_ch_two == 16'hffff &&
			$past(cnt_wr) == 3'h0 |-> status_flags[2])
		else $error("no wrap flag on underflow");
	a_tick_ignored:
		assert property ((phase_mode_bit && $stable(phase_input_a) && $stable(phase_input_b) &&
			cnt_wr == 3'h0 && clear_source_select == 2'h0)[*5] |=> $stable(counter_ch_two))
		else $error("count moved without a pin edge");
	a_capture_flag:
		assert property ($rose(timer_pin_a_two_in) && io_sel_a_two == 2'h1
			|-> ##[2:4] status_flags[0])
		else $error("capture flag late");
	a_level_invert:
		assert property ($changed(level_select_three) && (pwm_mode == 2'h1 || pwm_mode == 2'h2)
			&& $stable(pwm_mode) && !start_ch_three && gr_wr == 5'h0 && cnt_wr == 3'h0
			|=> timer_pin_a_three_out != $past(timer_pin_a_three_out))
		else $error("pin a3 not inverted");
	// Quadrature step three edges after a B edge
	a_quad_up:
		assert property (phase_mode_bit && start_ch_two && clear_source_select == 2'h0 &&
			(($rose(phase_input_b) && !phase_input_a) || ($fell(phase_input_b) && phase_input_a))
			|-> ##3 counter_ch_two == $past(counter_ch_two) + 16'h1)
		else $error("no up step");
	a_quad_down:
		assert property (phase_mode_bit && start_ch_two && clear_source_select == 2'h0 &&
			(($rose(phase_input_b) && phase_input_a) || ($fell(phase_input_b) && !phase_input_a))
			|-> ##3 counter_ch_two == $past(counter_ch_two) - 16'h1)
		else $error("no down step");
endmodule

bind tpc_top tpc_chk i_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .phase_input_a(phase_input_a),
	.phase_input_b(phase_input_b), .timer_pin_a_two_in(timer_pin_a_two_in),
	.phase_mode_bit(phase_mode_bit), .start_ch_two(start_ch_two),
	.start_ch_three(start_ch_three), .clear_source_select(clear_source_select),
	.pwm_mode(pwm_mode), .io_sel_a_two(io_sel_a_two), .level_select_three(level_select_three),
	.irq_enable(irq_enable), .gr_wr(gr_wr), .cnt_wr(cnt_wr), .status_wr(status_wr),
	.counter_ch_two(counter_ch_two), .status_flags(status_flags), .irq_req(irq_req),
	.timer_pin_a_three_out(timer_pin_a_three_out)
);

// ---- tpc_quad_src.sv ----
// Quadrature encoder model for the two phase pins.
// The bench requests steps; each pin edge follows a falling clock edge.
`timescale 1ns/10ps
module tpc_quad_src (
	input  wire logic sys_clk,
	output logic      phase_a,
	output logic      phase_b
);
	logic [1:0] pos_ff = 2'h0;

	// Gray order 00,01,11,10 counts up
	assign phase_a = pos_ff[1];
	assign phase_b = pos_ff[1] ^ pos_ff[0];

	// One pin edge, then hold at least three cycles
	task automatic step(input logic up, input int gap);
		@(negedge sys_clk);
		pos_ff = up ? pos_ff + 2'h1 : pos_ff - 2'h1;
		repeat ((gap < 3) ? 3 : gap) @(posedge sys_clk);
	endtask
endmodule

// ---- tpc_top_tb.sv ----
// Self-checking bench: quadrature count, flags, buffers, PWM levels.
// Uses the quadrature model and the bound checker.
`timescale 1ns/10ps
module tpc_top_tb
	import tpc_pkg::*;
;
	logic       sys_clk, rst_n, phase_input_a, phase_input_b, phase_mode_bit, pin_seen;
	logic       start_ch_two, start_ch_three, start_ch_four, tick_two, tick_three, tick_four;
	tpc_sel_t   clear_source_select, pwm_mode, io_sel_a_two, io_sel_b_two;
	tpc_sel_t   io_sel_a_three, io_sel_b_three, io_sel_b_four;
	logic       buffer_enable_a_three, buffer_enable_b_three, buffer_enable_b_four;
	logic       level_select_three, level_select_four, status_rd, status_wr;
	tpc_flags_t irq_enable, status_wdata, status_flags, irq_req;
	logic [4:0] gr_wr, br_wr, cap_pins;
	logic [2:0] cnt_wr;
	tpc_word_t  wdata, counter_ch_two, counter_ch_three, counter_ch_four;
	logic       pin_a3, pin_b3, pin_b4, pwm_drive;
	int         mismatches = 0;
	int         samples_checked = 0;
	int         flag_pos[5] = '{0, 1, 3, 4, 6};

	tpc_top i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .phase_input_a(phase_input_a),
		.phase_input_b(phase_input_b), .timer_pin_a_two_in(cap_pins[0]),
		.timer_pin_b_two_in(cap_pins[1]), .timer_pin_a_three_in(cap_pins[2]),
		.timer_pin_b_three_in(cap_pins[3]), .timer_pin_b_four_in(cap_pins[4]),
		.phase_mode_bit(phase_mode_bit), .start_ch_two(start_ch_two),
		.start_ch_three(start_ch_three), .start_ch_four(start_ch_four), .tick_two(tick_two),
		.tick_three(tick_three), .tick_four(tick_four), .clear_source_select(clear_source_select),
		.pwm_mode(pwm_mode), .io_sel_a_two(io_sel_a_two), .io_sel_b_two(io_sel_b_two),
		.io_sel_a_three(io_sel_a_three), .io_sel_b_three(io_sel_b_three),
		.io_sel_b_four(io_sel_b_four), .buffer_enable_a_three(buffer_enable_a_three),
		.buffer_enable_b_three(buffer_enable_b_three), .buffer_enable_b_four(buffer_enable_b_four),
		.level_select_three(level_select_three), .level_select_four(level_select_four),
		.irq_enable(irq_enable), .gr_wr(gr_wr), .br_wr(br_wr), .cnt_wr(cnt_wr), .wdata(wdata),
		.status_rd(status_rd), .status_wr(status_wr), .status_wdata(status_wdata),
		.counter_ch_two(counter_ch_two), .counter_ch_three(counter_ch_three),
		.counter_ch_four(counter_ch_four), .status_flags(status_flags), .irq_req(irq_req),
		.timer_pin_a_three_out(pin_a3), .timer_pin_b_three_out(pin_b3),
		.timer_pin_b_four_out(pin_b4), .pwm_drive(pwm_drive)
	);

	tpc_quad_src i_enc (
		.sys_clk(sys_clk),
		.phase_a(phase_input_a),
		.phase_b(phase_input_b)
	);

	// 200 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input tpc_word_t exp, input tpc_word_t got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Bounded wait for one status flag
	task automatic wait_flag(input int idx, input int limit);
		int n = 0;
		while (status_flags[idx] !== 1'b1 && n < limit) begin
			@(negedge sys_clk);
			n++;
		end
		cmp("flag", 16'h1, {15'h0, status_flags[idx]});
		if (status_flags[idx] !== 1'b1) begin
			end_of_test();
		end
	endtask

	// Kind 0 general, 1 buffer, 2 counter write
	task automatic wr(input int kind, input int slot, input tpc_word_t v);
		@(negedge sys_clk);
		wdata = v;
		case (kind)
			0: gr_wr[slot] = 1'b1;
			1: br_wr[slot] = 1'b1;
			default: cnt_wr[slot] = 1'b1;
		endcase
		@(negedge sys_clk);
		{gr_wr, br_wr, cnt_wr} = 13'h0;
	endtask

	// Optional read, then write zeros on mask bits
	task automatic clr(input tpc_flags_t mask, input logic do_read);
		@(negedge sys_clk);
		status_rd = do_read;
		@(negedge sys_clk);
		status_rd = 1'b0;
		status_wr = 1'b1;
		status_wdata = ~mask;
		@(negedge sys_clk);
		status_wr = 1'b0;
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge sys_clk);
			{tick_two, tick_three, tick_four} = 3'h7;
			@(negedge sys_clk);
			{tick_two, tick_three, tick_four} = 3'h0;
		end
	endtask

	task automatic quad(input logic up, input int n, input int gap);
		repeat (n) i_enc.step(up, gap);
		repeat (4) @(negedge sys_clk);
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		end_of_test();
	end

	// Main sequence
	initial begin
		{rst_n, phase_mode_bit, start_ch_two, start_ch_three, start_ch_four} = 5'h0;
		{tick_two, tick_three, tick_four, status_rd, status_wr, cap_pins} = 10'h0;
		{clear_source_select, pwm_mode, io_sel_a_two, io_sel_b_two} = 8'h0;
		{io_sel_a_three, io_sel_b_three, io_sel_b_four} = 6'h0;
		{buffer_enable_a_three, buffer_enable_b_three, buffer_enable_b_four} = 3'h0;
		{level_select_three, level_select_four} = 2'h3;
		{gr_wr, br_wr, cnt_wr, wdata, status_wdata} = 37'h0;
		irq_enable = 8'hff;
		repeat (5) @(negedge sys_clk);
		rst_n = 1'b1;
		cmp("flags after reset", 16'h0, {8'h0, status_flags});
		phase_mode_bit = 1'b1;
		start_ch_two = 1'b1;
		tick_two = 1'b1;
		quad(1'b1, 8, 3);
		cmp("count up", 16'h0008, counter_ch_two);
		quad(1'b0, 10, 7);
		cmp("count down", 16'hfffe, counter_ch_two);
		cmp("ch3 idle", 16'h0000, counter_ch_three);
		cmp("wrap down", 16'h1, {15'h0, status_flags[2]});
		cmp("irq on", 16'h1, {15'h0, irq_req[2]});
		irq_enable = 8'h00;
		@(negedge sys_clk);
		cmp("irq masked", 16'h0, {15'h0, irq_req[2]});
		irq_enable = 8'hff;
		clr(8'h04, 1'b0);
		cmp("kept unread", 16'h1, {15'h0, status_flags[2]});
		clr(8'h04, 1'b1);
		cmp("cleared", 16'h0, {15'h0, status_flags[2]});
		quad(1'b1, 2, 3);
		cmp("wrap to zero", 16'h0000, counter_ch_two);
		cmp("wrap up", 16'h1, {15'h0, status_flags[2]});
		tick_two = 1'b0;
		// Capture on every pin, channel 2 still in phase mode
		{io_sel_a_two, io_sel_b_two, io_sel_a_three, io_sel_b_three, io_sel_b_four} = 10'h155;
		clr(8'hff, 1'b1);
		for (int i = 0; i < 5; i++) begin
			cap_pins[i] = 1'b1;
			wait_flag(flag_pos[i], 8);
		end
		cap_pins = 5'h0;
		{io_sel_a_two, io_sel_b_two, io_sel_a_three, io_sel_b_three, io_sel_b_four} = 10'h0;
		// Compare A2 with clear: flag when leaving the value
		phase_mode_bit = 1'b0;
		clear_source_select = 2'h1;
		wr(0, 0, 16'h0005);
		wr(2, 0, 16'h0004);
		clr(8'hff, 1'b1);
		ticks(1);
		cmp("at match", 16'h0005, counter_ch_two);
		cmp("no flag yet", 16'h0, {15'h0, status_flags[0]});
		ticks(1);
		cmp("clear on match", 16'h0000, counter_ch_two);
		cmp("match flag", 16'h1, {15'h0, status_flags[0]});
		{clear_source_select, start_ch_two} = 3'h0;
		// Buffered capture B3 twice: 7 drops into the buffer, 2 stays
		{io_sel_b_three, buffer_enable_b_three} = 3'h3;
		wr(2, 1, 16'h0007);
		cap_pins[3] = 1'b1;
		repeat (4) @(negedge sys_clk);
		cap_pins[3] = 1'b0;
		wr(2, 1, 16'h0002);
		cap_pins[3] = 1'b1;
		repeat (4) @(negedge sys_clk);
		{io_sel_b_three, cap_pins} = 7'h0;
		// Buffered compare B3 on the captured values
		{buffer_enable_a_three, buffer_enable_b_three, buffer_enable_b_four} = 3'h7;
		wr(2, 1, 16'h0001);
		start_ch_three = 1'b1;
		clr(8'hff, 1'b1);
		ticks(2);
		cmp("b3 match", 16'h1, {15'h0, status_flags[4]});
		clr(8'h10, 1'b1);
		ticks(4);
		cmp("b3 quiet", 16'h0, {15'h0, status_flags[4]});
		ticks(1);
		cmp("b3 new value", 16'h1, {15'h0, status_flags[4]});
		start_ch_three = 1'b0;
		// Output level inversion while halted
		pwm_mode = 2'h1;
		repeat (2) @(negedge sys_clk);
		cmp("pins driven", 16'h1, {15'h0, pwm_drive});
		cmp("b4 before", 16'h1, {15'h0, pin_b4});
		pin_seen = pin_a3;
		{level_select_three, level_select_four} = 2'h0;
		repeat (2) @(negedge sys_clk);
		cmp("a3 inverted", {15'h0, ~pin_seen}, {15'h0, pin_a3});
		cmp("b3 opposite", {15'h0, pin_seen}, {15'h0, pin_b3});
		cmp("b4 inverted", 16'h0, {15'h0, pin_b4});
		{level_select_three, level_select_four, pwm_mode} = 4'hc;
		// Complementary: buffer value beyond period flattens the pin
		{buffer_enable_a_three, buffer_enable_b_four} = 2'h0;
		wr(0, 2, 16'h000a);
		wr(0, 3, 16'h0005);
		wr(1, 3, 16'h0020);
		wr(2, 1, 16'h0002);
		wr(2, 2, 16'h0000);
		pwm_mode = 2'h2;
		clr(8'hff, 1'b1);
		{start_ch_three, start_ch_four} = 2'h3;
		ticks(30);
		cmp("a3 period", 16'h1, {15'h0, status_flags[3]});
		cmp("ch4 under", 16'h1, {15'h0, status_flags[7]});
		cmp("ch3 count", 16'h000a, counter_ch_three);
		cmp("ch4 count", 16'h0008, counter_ch_four);
		pin_seen = pin_a3;
		for (int i = 0; i < 40; i++) begin
			ticks(1);
			cmp("flat a3", {15'h0, pin_seen}, {15'h0, pin_a3});
		end
		end_of_test();
	end
endmodule
